// [src/lsw_status_top.sv]
// LIN flag bank and fixed status word builder with its serial link
// assumes lin detector levels and cs_n are asynchronous pins; other-bank
// levels and ext_status come from logic on clock
//
// Function
// - dominant beyond timeout latches clamp flag
// - live transmit/receive state bit, read-proof
// - live wake-enable bit, unchanged by reads
// - wake flag set on wake, clear after wake ends+read
// - termination short flag, clear after recovery+read
// - overtemperature flag, clear when cool+read
// - receive-low flag, clear after recovery+read
// - receive-high flag, clear after recovery+read
// - transmit-dominant flag, clear after recovery+read
// - every frame returns fixed status, reads only
// - write frames add the extended status byte
// - bits 15-13 interrupt, wake, reset pending
// - bits 12-8 name the source group
// - bits 7/6 can bus/local, ored group
// - bit 5 zero, bit 4 LIN source
// - bits 3/2 high/low I/O page
// - bits 1/0 high/low regulator page
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_status_top #(
  parameter int DOM_CYCLES = `LSW_T_DOM_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 mosi,
  input  wire lsw_pkg::lsw_lin_in_s lin_in,
  input  wire lsw_pkg::lsw_other_s  other,
  input  wire logic [7:0]           ext_status,
  output logic                      miso,
  output logic                      miso_oe_n,
  output logic [15:0]               fixed_status_response,
  output logic [8:0]                lin_flag_word,
  output logic [15:0]               cmd_word,
  output logic                      cmd_strobe
);
  import lsw_pkg::*;
  localparam int DW = $clog2(DOM_CYCLES + 1);

  if (DOM_CYCLES < 1) begin : g_chk
    $error("lsw_status_top: DOM_CYCLES must be at least one");
  end

  lsw_lin_in_s             lin_meta_reg;
  lsw_lin_in_s             lin_sync_reg;
  logic                    cs_meta_reg;
  logic                    cs_sync_reg;
  logic                    done_meta_reg;
  logic                    done_sync_reg;
  logic                    done_seen_reg;
  logic [DW-1:0]           dom_cnt_reg;
  logic [DW-1:0]           dom_cnt_next;
  logic                    read_pulse_reg;
  logic                    strobe_reg;
  logic [15:0]             cmd_reg;
  logic [8:0]              lin_word_reg;
  lsw_status_s             hold_reg;
  lsw_status_s             hold_next;
  logic [`LSW_FLG_COUNT-1:0] flt_lvl;
  logic [`LSW_FLG_COUNT-1:0] flags;
  logic [15:0]             status_next;
  logic [15:0]             link_cmd;
  logic                    link_done;
  logic                    link_miso;
  logic                    link_oe_n;

  // pins pass two flops before any core-clock logic looks at them
  always_ff @(posedge clock) begin
    if (reset) begin
      lin_meta_reg  <= '0;
      lin_sync_reg  <= '0;
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
    end else begin
      lin_meta_reg  <= lin_in;
      lin_sync_reg  <= lin_meta_reg;
      cs_meta_reg   <= cs_n;
      cs_sync_reg   <= cs_meta_reg;
      done_meta_reg <= link_done;
      done_sync_reg <= done_meta_reg;
    end
  end

  wire dom_fault = dom_cnt_reg == DW'(DOM_CYCLES);
  assign dom_cnt_next = !lin_sync_reg.bus_dom ? '0 :
                        dom_fault ? dom_cnt_reg : dom_cnt_reg + DW'(1);

  always_ff @(posedge clock) begin
    if (reset) begin
      dom_cnt_reg <= '0;
    end else begin
      dom_cnt_reg <= dom_cnt_next;
    end
  end

  assign flt_lvl[`LSW_FLG_DOM]  = dom_fault;
  assign flt_lvl[`LSW_FLG_TERM] = lin_sync_reg.term_short;
  assign flt_lvl[`LSW_FLG_TEMP] = lin_sync_reg.over_temp;
  assign flt_lvl[`LSW_FLG_RXDL] = lin_sync_reg.rxd_low;
  assign flt_lvl[`LSW_FLG_RXDH] = lin_sync_reg.rxd_high;
  assign flt_lvl[`LSW_FLG_TXD]  = lin_sync_reg.txd_dom;
  assign flt_lvl[`LSW_FLG_WAKE] = lin_sync_reg.wake_evt;

  // same latch
  // a read taken while the fault is still present is not remembered
  for (genvar i = 0; i < `LSW_FLG_COUNT; i++) begin : g_flag
    lsw_fault_flag u_flag (
      .clock    (clock),
      .reset    (reset),
      .cond     (flt_lvl[i]),
      .read_clr (read_pulse_reg),
      .flag     (flags[i])
    );
  end

  // command word crosses as a held word qualified by the synced done level
  wire cmd_new      = done_sync_reg & ~done_seen_reg;
  wire cmd_flag_rd  = link_cmd == `LSW_LIN_FLAG_READ;

  always_ff @(posedge clock) begin
    if (reset) begin
      done_seen_reg  <= 1'b0;
      read_pulse_reg <= 1'b0;
      strobe_reg     <= 1'b0;
      cmd_reg        <= '0;
    end else begin
      done_seen_reg  <= done_sync_reg;
      read_pulse_reg <= cmd_new & cmd_flag_rd;
      strobe_reg     <= cmd_new;
      if (cmd_new) begin
        cmd_reg <= link_cmd;
      end
    end
  end

  // pending and source bits straight from the flags and the other-bank levels
  wire single_wire_source        = |flags;
  wire lin_int_any               = |flags[`LSW_FLG_TXD:`LSW_FLG_DOM];
  wire can_group                 = other.can_bus | other.transceiver_local_source;
  wire io_group                  = other.io_high | other.io_low;
  wire regulator_group_source    = other.regulator_high_page_source
                                 | other.regulator_low_page_source;
  wire wake_pending              = other.wake_pend | flags[`LSW_FLG_WAKE];

  assign status_next[`LSW_ST_INT]     = other.int_pend | lin_int_any;
  assign status_next[`LSW_ST_WAKE]    = wake_pending;
  assign status_next[`LSW_ST_RST]     = other.rst_pend;
  assign status_next[`LSW_ST_CAN_G]   = can_group;
  assign status_next[`LSW_ST_LIN_G]   = single_wire_source;
  assign status_next[`LSW_ST_IO_G]    = io_group;
  assign status_next[`LSW_ST_SAFE_G]  = other.safe;
  assign status_next[`LSW_ST_REG_G]   = regulator_group_source;
  assign status_next[`LSW_ST_CAN_BUS] = other.can_bus;
  assign status_next[`LSW_ST_TRANSCEIVER_LOCAL_SOURCE] = other.transceiver_local_source;
  assign status_next[`LSW_ST_ZERO]    = 1'b0;
  assign status_next[`LSW_ST_LIN]     = single_wire_source;
  assign status_next[`LSW_ST_IO_H]    = other.io_high;
  assign status_next[`LSW_ST_IO_L]    = other.io_low;
  assign status_next[`LSW_ST_REG_H]   = other.regulator_high_page_source;
  assign status_next[`LSW_ST_REG_L]   = other.regulator_low_page_source;

  // frozen during a frame so the link domain reads a stable word
  assign hold_next = cs_sync_reg ? lsw_status_s'{word: status_next, ext: ext_status} : hold_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      hold_reg     <= '0;
      lin_word_reg <= '0;
    end else begin
      hold_reg     <= hold_next;
      // live state beside the latched flags
      lin_word_reg <= {lin_sync_reg.trx_mode, lin_sync_reg.wake_en, flags};
    end
  end

  lsw_spi_link #(
    .FIX_BITS (`LSW_FIX_BITS),
    .EXT_BITS (`LSW_EXT_BITS)
  ) u_link (
    .sck       (sck),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .status    (hold_reg),
    .cmd_word  (link_cmd),
    .cmd_done  (link_done),
    .miso      (link_miso),
    .miso_oe_n (link_oe_n)
  );

  assign miso                  = link_miso;
  assign miso_oe_n             = link_oe_n;
  assign fixed_status_response = hold_reg.word;
  assign lin_flag_word         = lin_word_reg;
  assign cmd_word              = cmd_reg;
  assign cmd_strobe            = strobe_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_dom_expiring;
    (dom_cnt_reg == DW'(DOM_CYCLES - 1)) && lin_sync_reg.bus_dom;
  endsequence
  sequence s_read_taken;
    cmd_new && cmd_flag_rd;
  endsequence
  sequence s_single_clear;
    read_pulse_reg ##1 !read_pulse_reg;
  endsequence

  a_dom_clamp_set : assert property (
    s_dom_expiring |=> ##1 flags[`LSW_FLG_DOM])
    else $error("clamp flag missing after dominant timeout");
  a_dom_clamp_early : assert property (
    !flags[`LSW_FLG_DOM] && !dom_fault && !read_pulse_reg |=> !flags[`LSW_FLG_DOM])
    else $error("clamp flag set before timeout");
  a_live_state : assert property (
    lin_flag_word[8] == $past(lin_sync_reg.trx_mode))
    else $error("live state bit wrong");
  a_live_wake_en : assert property (
    read_pulse_reg |=> lin_flag_word[7] == $past(lin_sync_reg.wake_en))
    else $error("wake enable bit disturbed by read");
  a_wake_read_clear : assert property (
    read_pulse_reg && !flt_lvl[`LSW_FLG_WAKE] |=> !flags[`LSW_FLG_WAKE])
    else $error("wake flag survived its read");
  a_term_hold : assert property (
    flt_lvl[`LSW_FLG_TERM] |=> flags[`LSW_FLG_TERM] [*1])
    else $error("termination flag lost while short present");
  a_temp_hold : assert property (
    flags[`LSW_FLG_TEMP] && !read_pulse_reg |=> flags[`LSW_FLG_TEMP])
    else $error("overtemperature flag dropped without read");
  a_rxd_low_clear : assert property (
    read_pulse_reg && !flt_lvl[`LSW_FLG_RXDL] |=> !flags[`LSW_FLG_RXDL])
    else $error("receive-low flag not cleared by read");
  a_rxd_high_hold : assert property (
    read_pulse_reg && flt_lvl[`LSW_FLG_RXDH] |=> flags[`LSW_FLG_RXDH])
    else $error("receive-high flag cleared while fault present");
  a_txd_dom_set : assert property (
    $rose(lin_sync_reg.txd_dom) |=> flags[`LSW_FLG_TXD] && status_next[`LSW_ST_LIN])
    else $error("transmit-dominant flag not latched");
  a_flag_read_cmd : assert property (
    s_read_taken |=> s_single_clear)
    else $error("flag read command did not give one clear strobe");
  a_pending_bits : assert property (
    status_next[15:13] == {other.int_pend | lin_int_any, wake_pending, other.rst_pend})
    else $error("pending bits wrong");
  a_group_order : assert property (
    status_next[12:8] == {can_group, |flags, io_group, other.safe, regulator_group_source})
    else $error("group bits out of order");
  a_can_group : assert property (
    status_next[`LSW_ST_CAN_G] == (status_next[7] | status_next[6]))
    else $error("can group bit does not follow detail bits");
  a_zero_lin_bit : assert property (
    !status_next[5] && (status_next[4] == status_next[11]))
    else $error("bit 5 set or LIN bit mismatch");
  a_io_page : assert property (
    status_next[3:2] == {other.io_high, other.io_low})
    else $error("I/O page bits wrong");
  a_reg_page : assert property (
    status_next[1:0] == {other.regulator_high_page_source, other.regulator_low_page_source})
    else $error("regulator page bits wrong");
  a_status_clears : assert property (
    (flags == '0) && (other == '0) && cs_sync_reg |=> fixed_status_response == '0)
    else $error("status word not cleared with its flags");
  a_hold_frozen : assert property (
    !cs_sync_reg && !$past(cs_sync_reg) |-> $stable(hold_reg))
    else $error("status hold moved during a frame");
  a_dom_clamp_clear : assert property (
    read_pulse_reg && !dom_fault |=> !flags[`LSW_FLG_DOM])
    else $error("clamp flag survived read after recovery");
  a_wake_set : assert property (
    flt_lvl[`LSW_FLG_WAKE] |=> flags[`LSW_FLG_WAKE])
    else $error("wake flag not set by wake event");
  a_term_clear : assert property (
    read_pulse_reg && !flt_lvl[`LSW_FLG_TERM] |=> !flags[`LSW_FLG_TERM])
    else $error("termination flag not cleared by read");
  a_temp_live_read : assert property (
    read_pulse_reg && flt_lvl[`LSW_FLG_TEMP] |=> flags[`LSW_FLG_TEMP])
    else $error("overtemperature flag cleared while hot");
  a_rxd_low_set : assert property (
    flt_lvl[`LSW_FLG_RXDL] |=> flags[`LSW_FLG_RXDL])
    else $error("receive-low flag not latched");
  a_rxd_high_clear : assert property (
    read_pulse_reg && !flt_lvl[`LSW_FLG_RXDH] |=> !flags[`LSW_FLG_RXDH])
    else $error("receive-high flag not cleared by read");
  a_txd_dom_clear : assert property (
    read_pulse_reg && !flt_lvl[`LSW_FLG_TXD] |=> !flags[`LSW_FLG_TXD])
    else $error("transmit-dominant flag not cleared by read");
  a_status_follow : assert property (
    cs_sync_reg |=> fixed_status_response == $past(status_next))
    else $error("status word does not follow the flags");
  a_strobe_single : assert property (
    cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
endmodule : lsw_status_top

// [src/lsw_consts.svh]
// constants for the LIN flag bank and fixed status word
// assumes a 200 MHz core clock; included by bare name
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH

`define LSW_CLK_PERIOD_NS 5
// dominant clamp timeout; figure is a plain default, not a characterised value
`define LSW_T_DOM_US 50
// least time: round up to whole cycles
`define LSW_T_DOM_CYCLES (((`LSW_T_DOM_US * 1000) + `LSW_CLK_PERIOD_NS - 1) / `LSW_CLK_PERIOD_NS)

`define LSW_FIX_BITS 16
`define LSW_EXT_BITS 8
`define LSW_CMD_WRITE 2'h1
`define LSW_LIN_FLAG_READ 16'h2780

// latched flag indices
`define LSW_FLG_DOM 0
`define LSW_FLG_TERM 1
`define LSW_FLG_TEMP 2
`define LSW_FLG_RXDL 3
`define LSW_FLG_RXDH 4
`define LSW_FLG_TXD 5
`define LSW_FLG_WAKE 6
`define LSW_FLG_COUNT 7

// fixed status word bit positions
`define LSW_ST_INT 15
`define LSW_ST_WAKE 14
`define LSW_ST_RST 13
`define LSW_ST_CAN_G 12
`define LSW_ST_LIN_G 11
`define LSW_ST_IO_G 10
`define LSW_ST_SAFE_G 9
`define LSW_ST_REG_G 8
`define LSW_ST_CAN_BUS 7
`define LSW_ST_TRANSCEIVER_LOCAL_SOURCE 6
`define LSW_ST_ZERO 5
`define LSW_ST_LIN 4
`define LSW_ST_IO_H 3
`define LSW_ST_IO_L 2
`define LSW_ST_REG_H 1
`define LSW_ST_REG_L 0

`endif

// [src/lsw_pkg.sv]
// types shared by the LIN flag bank and its serial link
// assumes lsw_consts.svh supplies the numeric layout
package lsw_pkg;

  // raw LIN detector levels, asynchronous to the core clock
  typedef struct packed {
    logic trx_mode;
    logic wake_en;
    logic wake_evt;
    logic txd_dom;
    logic rxd_high;
    logic rxd_low;
    logic over_temp;
    logic term_short;
    logic bus_dom;
  } lsw_lin_in_s;

  // pending and source levels from the other flag banks, core clock domain
  typedef struct packed {
    logic int_pend;
    logic rst_pend;
    logic wake_pend;
    logic can_bus;
    logic transceiver_local_source;
    logic io_high;
    logic io_low;
    logic safe;
    logic regulator_high_page_source;
    logic regulator_low_page_source;
  } lsw_other_s;

  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  ext;
  } lsw_status_s;

endpackage : lsw_pkg

// [src/lsw_fault_flag.sv]
// one sticky flag: set by a condition level, cleared by a read strobe
// assumes both inputs are already in the clock domain
`timescale 1ns/1ps
module lsw_fault_flag (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic cond,
  input  wire logic read_clr,
  output logic      flag
);
  logic flag_reg;
  logic flag_next;

  // set wins over clear, and a live condition blocks the clear
  assign flag_next = cond | (flag_reg & ~read_clr);

  always_ff @(posedge clock) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule : lsw_fault_flag

// [src/lsw_spi_link.sv]
// serial link end: shifts the command in, the status word and extended byte out
// assumes sck idles low, mosi sampled on falling and miso driven on rising edge;
// status is held stable by the core while cs_n is low
`timescale 1ns/1ps
`include "lsw_consts.svh"
module lsw_spi_link #(
  parameter int FIX_BITS = `LSW_FIX_BITS,
  parameter int EXT_BITS = `LSW_EXT_BITS
) (
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 mosi,
  input  wire lsw_pkg::lsw_status_s status,
  output logic [FIX_BITS-1:0]       cmd_word,
  output logic                      cmd_done,
  output logic                      miso,
  output logic                      miso_oe_n
);
  import lsw_pkg::*;
  localparam int TOT = FIX_BITS + EXT_BITS;
  localparam int CW  = $clog2(TOT + 1);

  if (TOT != $bits(lsw_status_s) || FIX_BITS < 3) begin : g_chk
    $error("lsw_spi_link: widths do not match the status layout");
  end

  logic [CW-1:0]       rx_cnt_reg;
  logic [FIX_BITS-2:0] rx_sh_reg;
  logic                write_reg;
  logic                done_reg;
  logic [FIX_BITS-1:0] cmd_reg;
  logic [CW-1:0]       tx_cnt_reg;
  logic [TOT-2:0]      tx_sh_reg;
  logic                miso_reg;
  logic                oe_n_reg;

  wire rx_last            = rx_cnt_reg == CW'(FIX_BITS - 1);
  wire [CW-1:0] rx_cnt_next = (rx_cnt_reg == CW'(TOT)) ? rx_cnt_reg : rx_cnt_reg + CW'(1);
  wire tx_first           = tx_cnt_reg == '0;
  // length by type
  // a read frame ends after the fixed word; zeros follow
  wire tx_cut             = (tx_cnt_reg == CW'(FIX_BITS)) && !write_reg;
  wire [CW-1:0] tx_cnt_next = (tx_cnt_reg == CW'(TOT)) ? tx_cnt_reg : tx_cnt_reg + CW'(1);
  wire [TOT-1:0] tx_next  = tx_first ? TOT'(status) :
                            tx_cut   ? '0 : {tx_sh_reg, 1'b0};

  // frame state ends with the frame: cs_n high clears it without an sck edge
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_reg <= '0;
      rx_sh_reg  <= '0;
      write_reg  <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg  <= {rx_sh_reg[FIX_BITS-3:0], mosi};
      if (rx_cnt_reg == CW'(1)) begin
        write_reg <= ({rx_sh_reg[0], mosi} == `LSW_CMD_WRITE);
      end
      if (rx_last) begin
        done_reg <= 1'b1;
      end
    end
  end

  // command word is held until the next full command, read by the core
  always_ff @(negedge sck) begin
    if (rx_last) begin
      cmd_reg <= {rx_sh_reg, mosi};
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_reg <= '0;
      tx_sh_reg  <= '0;
      miso_reg   <= 1'b0;
      oe_n_reg   <= 1'b1;
    end else begin
      tx_cnt_reg            <= tx_cnt_next;
      {miso_reg, tx_sh_reg} <= tx_next;
      oe_n_reg              <= 1'b0;
    end
  end

  assign cmd_word  = cmd_reg;
  assign cmd_done  = done_reg;
  assign miso      = miso_reg;
  assign miso_oe_n = oe_n_reg;

  property p_first_bit;
    @(posedge sck) disable iff (cs_n)
      tx_first |=> miso == $past(status.word[FIX_BITS-1]);
  endproperty
  a_first_status_bit : assert property (p_first_bit)
    else $error("first status bit not driven on miso");
  a_read_fix_only : assert property (
    @(posedge sck) disable iff (cs_n) tx_cut |=> !miso [*2])
    else $error("read frame drove data after the fixed word");
  a_write_ext_byte : assert property (
    @(posedge sck) disable iff (cs_n)
      (tx_cnt_reg == CW'(FIX_BITS)) && write_reg |=> miso == $past(status.ext[EXT_BITS-1]))
    else $error("write frame did not send the extended byte");
endmodule : lsw_spi_link

// [sim/lsw_host_model.sv]
// host serial master: frames of 24 clocked bits, command first, status captured
// assumes the link samples mosi on falling sck and updates miso on rising sck
`timescale 1ns/1ps
module lsw_host_model (
  output logic        sck,
  output logic        cs_n,
  output logic        mosi,
  input  wire logic   miso,
  output logic [23:0] rx,
  output logic        done
);
  localparam time HALF = 24ns;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx = 24'h000000;
    done = 1'b0;
    // a rising select after time zero clears the link's frame state for sure
    #1;
    cs_n = 1'b1;
  end

  task automatic frame(input logic [15:0] cmd);
    logic [23:0] tx;
    tx = {cmd, 8'h00};
    cs_n = 1'b0;
    #HALF;
    // command msb first, type in top two bits
    for (int k = 23; k >= 0; k--) begin
      sck = 1'b1;
      mosi = tx[k];
      #HALF;
      sck = 1'b0;
      rx[k] = miso;
      #HALF;
    end
    // released line: show the opposite of the last bit, never a stale value
    mosi = ~mosi;
    cs_n = 1'b1;
    done = 1'b1;
    #HALF;
    done = 1'b0;
    #HALF;
  endtask : frame
endmodule : lsw_host_model

// [sim/lin_flags_spi_status_word_test.sv]
// self-checking bench for the LIN flag bank and its status word link
// assumes lsw_host_model as serial master; sck runs only inside frames
`timescale 1ns/1ps
module lin_flags_spi_status_word_test;
  import lsw_pkg::*;
  localparam int DOM = 20;
  logic        clock, reset, sck, cs_n, mosi, miso, miso_pin, miso_oe_n;
  logic        cmd_strobe, done;
  lsw_lin_in_s lin_in;
  lsw_other_s  other;
  logic [7:0]  ext_status;
  logic [15:0] fixed_status_response, cmd_word;
  logic [8:0]  lin_flag_word;
  logic [23:0] rx;
  logic [6:0]  fl;
  logic [23:0] rx_q[$];
  logic [15:0] cmd_q[$];
  int          fail_count, checks;

  // undriven pin shows the inverse so a stale bit cannot pass
  assign miso_pin = (miso_oe_n === 1'b0) ? miso : ~miso;

  lsw_status_top #(.DOM_CYCLES(DOM)) uut (
    .clock(clock), .reset(reset), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .lin_in(lin_in), .other(other), .ext_status(ext_status), .miso(miso),
    .miso_oe_n(miso_oe_n), .fixed_status_response(fixed_status_response),
    .lin_flag_word(lin_flag_word), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe));

  lsw_host_model host (
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_pin), .rx(rx), .done(done));

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    if (rx_q.size() != 0 || cmd_q.size() != 0) fail_count++;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  function automatic logic [15:0] exp_word(input lsw_other_s o, input logic [6:0] f);
    logic lin;
    lin = |f;
    return {o.int_pend | (|f[5:0]), o.wake_pend | f[6], o.rst_pend,
      o.can_bus | o.transceiver_local_source, lin, o.io_high | o.io_low, o.safe,
      o.regulator_high_page_source | o.regulator_low_page_source,
      o.can_bus, o.transceiver_local_source, 1'b0, lin, o.io_high, o.io_low,
      o.regulator_high_page_source, o.regulator_low_page_source};
  endfunction : exp_word

  // word is frozen at frame start, so the note is taken before the frame
  task automatic send(input logic [15:0] cmd);
    logic [7:0] tail;
    tail = (cmd[15:14] === 2'b01) ? ext_status : 8'h00;
    rx_q.push_back({exp_word(other, fl), tail});
    cmd_q.push_back(cmd);
    host.frame(cmd);
    // a read with the fault still live is lost
    if (cmd === 16'h2780) fl = fl & lin_in[6:0];
    repeat (12) @(posedge clock);
  endtask : send

  task automatic settle;
    repeat (10) @(posedge clock);
    check({8'h00, fixed_status_response}, {8'h00, exp_word(other, fl)});
    check({15'h0, lin_flag_word}, {15'h0, lin_in.trx_mode, lin_in.wake_en, fl});
    check({23'h0, miso_oe_n}, 24'h000001);
  endtask : settle

  always @(posedge done) begin
    if (rx_q.size() == 0) fail_count++;
    else check(rx, rx_q.pop_front());
  end

  always @(posedge clock) begin
    if (cmd_strobe === 1'b1 && cmd_q.size() > 0)
      check({8'h00, cmd_word}, {8'h00, cmd_q.pop_front()});
  end

  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h3818ca45));
    reset = 1'b1;
    lin_in = '0;
    other = '0;
    ext_status = 8'h00;
    fl = '0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    // random other-bank levels, every command type
    for (int t = 0; t < 12; t++) begin
      @(posedge clock);
      other <= lsw_other_s'(10'($urandom));
      ext_status <= 8'($urandom);
      @(posedge clock);
      send({2'(t), 14'($urandom)});
      settle();
    end
    @(posedge clock);
    other <= '0;
    // dominant shorter than the timeout is ignored
    lin_in.bus_dom <= 1'b1;
    repeat (DOM - 10) @(posedge clock);
    lin_in.bus_dom <= 1'b0;
    settle();
    // set, read while live, recover, read
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      lin_in[i] <= 1'b1;
      repeat (DOM + 10) @(posedge clock);
      fl[i] = 1'b1;
      settle();
      send(16'h2780);
      settle();
      lin_in[i] <= 1'b0;
      settle();
      send(16'h2780);
      settle();
    end
    // live bits survive the flag read
    for (int j = 0; j < 4; j++) begin
      @(posedge clock);
      {lin_in.trx_mode, lin_in.wake_en} <= 2'(j);
      settle();
      send(16'h2780);
      settle();
    end
    end_sim();
  end
endmodule : lin_flags_spi_status_word_test
